// ---- logic/dcr_pkg.sv ----
// ============================================================
// Purpose: Shared constants for the device ID and configuration readout block
// Assumes: Serial link commands are 4 bits, instruction words 24 bits, LSB first
// Notes:   Instruction encodings cover only the subset the readout flow needs
package dcr_pkg;
	// ============================================================
	// Serial link framing
	localparam logic [3:0] CMD_EXEC = 4'h0;        // Execute shifted instruction
	localparam logic [3:0] CMD_SHOUT = 4'h1;       // register_shift_out_cmd
	localparam logic [4:0] CMD_BITS = 5'h04;
	localparam logic [4:0] INSTR_BITS = 5'h18;
	localparam logic [4:0] GAP_BITS = 5'h08;       // Gap clocks; the first output bit is driven on the last one
	localparam logic [4:0] OUT_BITS = 5'h10;

	// ============================================================
	// Data space addresses of special registers
	localparam logic [15:0] ADDR_VISI = 16'h0784;  // visibility_output_word
	localparam logic [15:0] ADDR_TABLE_PAGE_REGISTER = 16'h0032; // table_page_register
	localparam logic [7:0] TABLE_PAGE_REGISTER_RST = 8'h00;

	// ============================================================
	// Nonvolatile map
	localparam logic [23:0] ADDR_DEV_CODE = 24'hff0000; // device_type_code
	localparam logic [23:0] ADDR_REV_WORD = 24'hff0002; // silicon_revision_word
	localparam logic [7:0] CFG_PAGE = 8'hf8;
	localparam logic [2:0] CFG_WORDS = 3'h7;

	// ============================================================
	// Revision word layout
	localparam int PROCESS_FIELD_LSB = 12;
	localparam int MAJOR_LSB = 6;
	localparam int MINOR_LSB = 0;
	localparam logic [3:0] PROCESS_FIELD_VALUE = 4'h1;
	localparam logic [5:0] REV_A = 6'h00;
	localparam logic [5:0] REV_B = 6'h01;
	localparam logic [5:0] REV_C = 6'h02;

	// ============================================================
	// Instruction opcodes
	localparam logic [7:0] OP_GOTO = 8'h04;
	localparam logic [7:0] OP_MOVF = 8'h88;        // MOV Wn to file register
	localparam logic [7:0] OP_CLR = 8'heb;
	localparam logic [7:0] OP_TBLRD = 8'hba;       // table_read_low_instr
	localparam logic [3:0] OP_MOVL = 4'h2;         // MOV #lit16 to Wn
	localparam logic [2:0] MODE_DIRECT = 3'h0;
	localparam logic [2:0] MODE_POSTINC = 3'h3;
	localparam logic [23:0] PC_STEP = 24'h000002;

	typedef enum logic [1:0] {ST_CMD, ST_DATA, ST_GAP, ST_OUT} dcr_state_e;
endpackage

// ---- logic/dcr_id_cfg_rom.sv ----
// ============================================================
// Purpose: Read-only lookup of ID words and configuration words by table address
// Assumes: Address is the 24-bit {page, offset} of a table read
// Notes:   Purely combinational; hit_o low marks unimplemented memory
`timescale 1ns/10ps
module dcr_id_cfg_rom
	import dcr_pkg::*;
#(
	parameter logic [15:0] DEV_CODE = 16'h5a3c,  // Arbitrary value
	parameter logic [5:0] MAJOR_REV = REV_A,
	parameter logic [5:0] MINOR_REV = 6'h00
) (
	input wire logic [23:0] addr_i,              // Table read address
	input wire logic [6:0][15:0] cfg_words_i,    // Configuration word contents
	output logic [15:0] data_o,                  // Word read
	output logic hit_o                           // Address is implemented
);
	logic [15:0] rev_word;

	// ============================================================
	// Revision word assembly
	always_comb begin
		rev_word = '0;
		rev_word[PROCESS_FIELD_LSB +: 4] = PROCESS_FIELD_VALUE;     // R04
		rev_word[MAJOR_LSB +: 6] = MAJOR_REV;     // R05
		rev_word[MINOR_LSB +: 6] = MINOR_REV;     // R06
	end

	// ============================================================
	// Address decode; ID words carry no protection gate so they stay visible
	always_comb begin
		data_o = '0;
		hit_o = 1'b0;
		if (addr_i == ADDR_DEV_CODE) begin
			data_o = DEV_CODE;                     // R03
			hit_o = 1'b1;                          // R02
		end else if (addr_i == ADDR_REV_WORD) begin
			data_o = rev_word;                     // R01
			hit_o = 1'b1;
		end else if (addr_i[23:16] == CFG_PAGE && addr_i[15:4] == '0 && !addr_i[0]
			&& addr_i[3:1] < CFG_WORDS) begin
			data_o = cfg_words_i[addr_i[3:1]];
			hit_o = 1'b1;
		end
	end
endmodule // dcr_id_cfg_rom

// ---- logic/dcr_readout_top.sv ----
// ============================================================
// Purpose: Device end of the serial programming link for ID and config readout
// Assumes: Programmer drives PGC and sets PGD before each rising PGC edge
// Notes:   Small instruction executor; only the readout instruction subset
// Operation
// R01: Two 16-bit ID words are readable by the word read path of the executive.
// R02: ID words are read-only and read true even under code protection.
// R03: The lower ID word holds the full 16-bit device type code.
// R04: The revision word holds a process field that always reads one in its top bits.
// R05: The revision word holds a six-bit major revision, 0 for A, 1 for B, 2 for C.
// R06: The revision word holds a six-bit binary minor revision in its low bits.
// R07: The programmer reads configuration as seven 16-bit words, one at a time.
// R08: The programmer sets the table page to the config page and clears both pointers.
// R09: The programmer first shifts two jumps to 0x100 and one no-operation.
// R10: Per word the programmer does a table read, two nops, a move to visibility, a nop.
// R11: On the shift-out command the device sends the visibility word, then a nop follows.
// R12: After each word the programmer jumps to 0x100 and issues a nop.
// R13: The programmer repeats the read, output and jump steps six more times.
// R14: A read of unimplemented memory resets the executive instead of returning data.
// R15: On the execute command the device executes the 24-bit instruction shifted in.
`timescale 1ns/10ps
module dcr_readout_top
	import dcr_pkg::*;
#(
	parameter logic [15:0] DEV_CODE = 16'h5a3c,  // Arbitrary value
	parameter logic [5:0] MAJOR_REV = REV_A,
	parameter logic [5:0] MINOR_REV = 6'h00
) (
	input wire logic clock_i,                    // 200 MHz system clock
	input wire logic rst_b_i,                    // Async reset, active low
	input wire logic pgc_i,                      // Serial clock pin
	input wire logic pgd_i,                      // Serial data pin input
	input wire logic [6:0][15:0] cfg_words_i,    // Configuration word contents
	output logic pgd_o,                          // Serial data pin output
	output logic pgd_oe_o,                       // Serial data drive enable
	output logic exec_reset_o,                   // Executive reset pulse
	output logic [23:0] exec_pc_o                // Executor program counter
);
	typedef struct packed {
		logic pgc_s1;
		logic pgc_s2;
		logic pgc_s3;
		logic pgd_s1;
		logic pgd_s2;
		dcr_state_e state;
		logic [4:0] cnt;
		logic [3:0] cmd;
		logic [23:0] shreg;
		logic [15:0][15:0] wreg;
		logic [7:0] table_page_register;
		logic [15:0] visi;
		logic [23:0] pc;
		logic pgd_o;
		logic pgd_oe;
		logic xrst;
	} dcr_regs_s;

	dcr_regs_s q_r;
	dcr_regs_s q_nxt;
	logic [1:0] rst_sync_r;
	logic rst_b;
	logic rise;
	logic exec;
	logic [23:0] instr;
	logic [15:0] src_val;
	logic [23:0] rd_addr;
	logic [15:0] rd_data;
	logic rd_ok;

	// ============================================================
	// Reset release through two flops
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_r[1];

	// ============================================================
	// Decode helpers; the full instruction includes the bit being sampled now
	assign rise = q_r.pgc_s2 & ~q_r.pgc_s3;
	assign exec = rise && q_r.state == ST_DATA && q_r.cnt == INSTR_BITS - 5'h01;
	assign instr = {q_r.pgd_s2, q_r.shreg[23:1]};
	assign src_val = q_r.wreg[instr[3:0]];
	assign rd_addr = {q_r.table_page_register, src_val};

	dcr_id_cfg_rom #(
		.DEV_CODE(DEV_CODE),
		.MAJOR_REV(MAJOR_REV),
		.MINOR_REV(MINOR_REV)
	) u_rom (
		.addr_i(rd_addr),
		.cfg_words_i(cfg_words_i),
		.data_o(rd_data),
		.hit_o(rd_ok)
	);

	// ============================================================
	// Next-state: pin sync, link framing and instruction execution
	always_comb begin
		q_nxt = q_r;
		q_nxt.pgc_s1 = pgc_i;
		q_nxt.pgc_s2 = q_r.pgc_s1;
		q_nxt.pgc_s3 = q_r.pgc_s2;
		q_nxt.pgd_s1 = pgd_i;
		q_nxt.pgd_s2 = q_r.pgd_s1;
		q_nxt.xrst = 1'b0;
		if (rise) begin
			unique case (q_r.state)
				ST_CMD: begin
					q_nxt.cmd = {q_r.pgd_s2, q_r.cmd[3:1]};
					q_nxt.cnt = q_r.cnt + 5'h01;
					if (q_r.cnt == CMD_BITS - 5'h01) begin
						q_nxt.cnt = '0;
						// Unknown command codes are dropped and framing restarts
						if (q_nxt.cmd == CMD_EXEC) begin
							q_nxt.state = ST_DATA;
						end else if (q_nxt.cmd == CMD_SHOUT) begin
							q_nxt.state = ST_GAP;
						end
					end
				end
				ST_DATA: begin
					q_nxt.shreg = instr;
					q_nxt.cnt = q_r.cnt + 5'h01;
					if (exec) begin
						q_nxt.cnt = '0;
						q_nxt.state = ST_CMD;
					end
				end
				ST_GAP: begin
					q_nxt.cnt = q_r.cnt + 5'h01;
					if (q_r.cnt == GAP_BITS - 5'h01) begin
						q_nxt.state = ST_OUT;
						q_nxt.cnt = 5'h01;
						q_nxt.pgd_oe = 1'b1;           // R11
						q_nxt.pgd_o = q_r.visi[0];
					end
				end
				ST_OUT: begin
					if (q_r.cnt == OUT_BITS) begin
						q_nxt.pgd_oe = 1'b0;
						q_nxt.pgd_o = 1'b0;
						q_nxt.cnt = '0;
						q_nxt.state = ST_CMD;
					end else begin
						q_nxt.pgd_o = q_r.visi[q_r.cnt[3:0]]; // R11
						q_nxt.cnt = q_r.cnt + 5'h01;
					end
				end
			endcase
		end
		// Pipeline stalls are not modelled, so the programmer's nops are harmless
		if (exec) begin
			q_nxt.pc = q_r.pc + PC_STEP;
			case (instr[23:16])
				OP_GOTO: q_nxt.pc = {8'h00, instr[15:0]};
				OP_MOVF: begin
					if ({instr[18:4], 1'b0} == ADDR_VISI) begin
						q_nxt.visi = src_val;          // R15
					end else if ({instr[18:4], 1'b0} == ADDR_TABLE_PAGE_REGISTER) begin
						q_nxt.table_page_register = src_val[7:0];
					end
				end
				OP_CLR: q_nxt.wreg[instr[10:7]] = '0;
				OP_TBLRD: begin
					if (!rd_ok) begin
						// Unimplemented memory: executive state returns to reset
						q_nxt.wreg = '0;               // R14
						q_nxt.table_page_register = TABLE_PAGE_REGISTER_RST;
						q_nxt.visi = '0;
						q_nxt.pc = '0;
						q_nxt.xrst = 1'b1;
					end else begin
						// Indirect targets only reach W0..W15 through pointer bits 4:1
						if (instr[13:11] == MODE_DIRECT) begin
							q_nxt.wreg[instr[10:7]] = rd_data; // R01
						end else begin
							q_nxt.wreg[q_r.wreg[instr[10:7]][4:1]] = rd_data;
						end
						if (instr[6:4] == MODE_POSTINC) begin
							q_nxt.wreg[instr[3:0]] = src_val + 16'h0002;
						end
					end
				end
				default: begin
					if (instr[23:20] == OP_MOVL) begin
						q_nxt.wreg[instr[3:0]] = instr[19:4]; // R15
					end
				end
			endcase
		end
	end

	// ============================================================
	// State register
	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign pgd_o = q_r.pgd_o;
	assign pgd_oe_o = q_r.pgd_oe;
	assign exec_reset_o = q_r.xrst;
	assign exec_pc_o = q_r.pc;

	// ============================================================
	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b);

	a_oe_out_phase: assert property (pgd_oe_o |-> q_r.state == ST_OUT) // R11
		else $error("data driven outside output phase");
	a_first_out_bit: assert property ((rise && q_r.state == ST_GAP && q_r.cnt == 5'h07)
		|=> (pgd_oe_o && pgd_o == q_r.visi[0])) // R11
		else $error("first output bit wrong");
	a_out_release: assert property ((rise && q_r.state == ST_OUT && q_r.cnt == 5'h10)
		|=> (!pgd_oe_o && q_r.state == ST_CMD)) // R11
		else $error("output not released after 16 bits");
	a_id_code: assert property ((rd_addr == 24'hff0000) |-> (rd_ok && rd_data == DEV_CODE)) // R03
		else $error("device code read wrong");
	a_rev_process_field: assert property ((rd_addr == 24'hff0002)
		|-> (rd_ok && rd_data[15:12] == 4'h1)) // R04
		else $error("process field wrong");
	a_rev_major: assert property ((rd_addr == 24'hff0002) |-> rd_data[11:6] == MAJOR_REV) // R05
		else $error("major revision field wrong");
	a_rev_minor: assert property ((rd_addr == 24'hff0002) |-> rd_data[5:0] == MINOR_REV) // R06
		else $error("minor revision field wrong");
	a_bad_read_reset: assert property ((exec && instr[23:16] == OP_TBLRD && !rd_ok)
		|=> (exec_reset_o && q_r.table_page_register == 8'h00) ##1 !exec_reset_o) // R14
		else $error("unimplemented read did not reset");
	a_visi_load: assert property ((exec && instr[23:16] == OP_MOVF
		&& {instr[18:4], 1'b0} == 16'h0784) |=> q_r.visi == $past(src_val)) // R15
		else $error("visibility word not loaded");
endmodule // dcr_readout_top

// ---- test/dcr_prog_model.sv ----
// ============================================================
// Purpose: Programmer model that drives the serial link of the readout block
// Assumes: PGC phases of HALF clocks meet the device's three-clock sampling
// Notes:   A released PGD toggles every bit so that a stale level never passes
`timescale 1ns/10ps
module dcr_prog_model
	import dcr_pkg::*;
#(
	parameter int HALF = 6  // Clocks per PGC phase
) (
	input wire logic clock_i,   // System clock
	input wire logic pgd_i,     // Resolved PGD level
	input wire logic pgd_oe_i,  // Device drives PGD
	output logic pgc_o,         // Serial clock
	output logic pgd_o          // Programmer PGD drive
);
	// ============================================================
	// Link idle: the clock stands low between frames
	initial begin
		pgc_o = 1'b0;
		pgd_o = 1'b0;
	end

	// Edges land just after the system clock, never on it
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// One PGC pulse; the line is sampled just before the fall
	task automatic pulse(input logic drv, input logic b, output logic s, output logic oe);
		pgd_o = drv ? b : ~pgd_o;
		wait_clk(HALF);
		pgc_o = 1'b1;
		wait_clk(HALF);
		s = pgd_i;
		oe = pgd_oe_i;
		pgc_o = 1'b0;
	endtask

	// Execute command, then the instruction, both LSB first
	task automatic exec(input logic [23:0] ins);
		logic [27:0] f;
		logic s;
		logic oe;
		f = {ins, CMD_EXEC};
		for (int i = 0; i < 28; i++) begin
			pulse(1'b1, f[i], s, oe);
		end
		wait_clk(HALF);
	endtask

	// Shift-out command; PGD released for gap and data, drive window checked
	task automatic shout(output logic [15:0] w, output logic ok);
		logic [3:0] c;
		logic s;
		logic oe;
		c = CMD_SHOUT;
		ok = 1'b1;
		w = 16'h0000;
		for (int i = 0; i < 28; i++) begin
			pulse(i < 4, c[i[1:0]], s, oe);
			if (i >= 11 && i < 27) begin
				w[i - 11] = s;
			end
			ok &= (oe === (i >= 11 && i < 27));
		end
		wait_clk(HALF);
	endtask
endmodule // dcr_prog_model

// ---- test/dcr_readout_top_tb.sv ----
// ============================================================
// Purpose: Self-checking bench for the ID and configuration readout block
// Assumes: The programmer model supplies all link timing
// Notes:   Expected words come from the bench's own table and parameters
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module dcr_readout_top_tb
	import dcr_pkg::*;
;
	localparam logic [15:0] DEV_CODE = 16'hc35a;  // Arbitrary value
	localparam logic [5:0] MINOR_REV = 6'h03;
	logic clock_i;
	logic rst_b_i;
	logic pgc;
	logic pgd_prog;
	logic pgd_dev;
	logic pgd_oe;
	logic exec_reset;
	logic [23:0] exec_pc;
	logic [6:0][15:0] cfg_words;
	logic pgd_wire;
	int n_fail = 0;
	int n_checks = 0;
	int n_pulse = 0;

	// ============================================================
	// Wire level: device wins while it drives
	assign pgd_wire = pgd_oe ? pgd_dev : pgd_prog;

	dcr_readout_top #(.DEV_CODE(DEV_CODE), .MAJOR_REV(REV_C), .MINOR_REV(MINOR_REV))
	u_dcr_readout_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .pgc_i(pgc), .pgd_i(pgd_wire),
		.cfg_words_i(cfg_words), .pgd_o(pgd_dev), .pgd_oe_o(pgd_oe),
		.exec_reset_o(exec_reset), .exec_pc_o(exec_pc));

	dcr_prog_model u_dcr_prog_model (.clock_i(clock_i), .pgd_i(pgd_wire), .pgd_oe_i(pgd_oe),
		.pgc_o(pgc), .pgd_o(pgd_prog));

	// 200 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// Count executive reset cycles; a pulse must be exactly one cycle
	always @(posedge clock_i) begin
		if (exec_reset === 1'b1) n_pulse++;
	end

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic run(input logic [23:0] q[$]);
		foreach (q[i]) u_dcr_prog_model.exec(q[i]);
	endtask

	// One pass: table read, move to visibility, shift out, jump back to 0x100
	task automatic read_word(input logic [15:0] exp);
		logic [15:0] w;
		logic ok;
		run('{24'hba0bb6, 24'h000000, 24'h000000, 24'h883c20, 24'h000000});
		u_dcr_prog_model.shout(w, ok);
		`CHK(w, exp)
		`CHK(ok, 1'b1)
		run('{24'h000000, 24'h040100, 24'h000000});
		`CHK(exec_pc, 24'h000102)
	endtask

	// Hang guard: a stuck sequence still reaches the verdict
	initial begin
		repeat (90000) @(posedge clock_i);
		n_fail++;
		$display("unexpected at %0t: run did not finish", $time);
		report_and_stop();
	end

	// ============================================================
	// Main sequence
	initial begin
		logic [15:0] w;
		logic ok;
		rst_b_i = 1'b0;
		for (int k = 0; k < 7; k++) cfg_words[k] = 16'h8001 + 16'(k) * 16'h1357;
		repeat (12) @(posedge clock_i);
		`CHK(pgd_oe, 1'b0)
		`CHK(exec_pc, 24'h000000)
		#1 rst_b_i = 1'b1;
		u_dcr_prog_model.wait_clk(6);
		run('{24'h040100, 24'h040100, 24'h000000});
		`CHK(exec_pc, 24'h000102)
		run('{24'h200f80, 24'h880190, 24'heb0300, 24'heb0380, 24'h000000});
		// Seven configuration words, first pass plus six repeats
		for (int k = 0; k < 7; k++) read_word(cfg_words[k]);
		// ID words under the same word read path
		run('{24'h200ff0, 24'h880190, 24'heb0300, 24'h000000});
		read_word(DEV_CODE);
		read_word({PROCESS_FIELD_VALUE, REV_C, MINOR_REV});
		// Direct destination into W1 with no pointer step; the device code lands in W1
		run('{24'heb0300, 24'hba0086, 24'h000000, 24'h000000, 24'h883c21, 24'h000000});
		u_dcr_prog_model.shout(w, ok);
		`CHK(w, DEV_CODE)
		`CHK(ok, 1'b1)
		run('{24'h000000});
		`CHK(n_pulse, 0)
		// Page zero is unimplemented: executive resets, nothing is returned
		run('{24'h200000, 24'h880190, 24'heb0300, 24'hba0bb6});
		`CHK(n_pulse, 1)
		`CHK(exec_pc, 24'h000000)
		u_dcr_prog_model.shout(w, ok);
		`CHK(w, 16'h0000)
		`CHK(ok, 1'b1)
		report_and_stop();
	end
endmodule // dcr_readout_top_tb
